// [rtl/exc_entry.sv]
// exception entry, state word and save/restore registers of the core
`timescale 1ns/1ps
`include "exc_entry_regs.svh"

module exc_entry
    import exc_entry_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // exception sources
    input wire logic sys_reset_req,
    input wire logic [3:0] mchk_src,
    input wire logic ext_irq,
    input wire logic dec_irq,
    input wire logic mgmt_irq,
    input wire logic fp_enabled_exc,
    input wire logic fp_instr_pending,
    input wire logic sync_exc,
    input wire logic [19:0] sync_vector,
    input wire logic [3:0] sync_info,
    // pipeline status
    input wire logic older_exc_pending,
    input wire logic instr_complete,
    input wire logic branch_complete,
    input wire logic [31:0] complete_pc,
    input wire logic [31:0] next_pc,
    // redirect and mode outputs
    output logic exc_taken,
    output logic [31:0] exc_fetch_addr,
    output logic fp_dispatch_ok,
    output logic instr_xlate_on,
    output logic data_xlate_on,
    output logic byte_order_swap,
    output logic checkstop
);

    exc_regs_t cur;
    exc_regs_t nxt;

    // a field of the state word by its big-endian bit number
    function automatic logic fld(input logic [31:0] w, input int pos);
        fld = w[31 - pos];
    endfunction : fld

    // vector base from the prefix field
    function automatic logic [31:0] vec_addr(input logic [31:0] w, input logic [19:0] off);
        vec_addr = {(fld(w, `POS_VECTOR_HIGH) ? `VEC_BASE_HIGH : `VEC_BASE_LOW), off};
    endfunction : vec_addr

    logic mchk_any;
    logic async_req;
    logic fp_prog_req;
    logic trace_req;
    logic [3:0] kind;
    logic [19:0] voff;
    logic [31:0] save_addr;
    logic [3:0] info;
    logic want;

    // source qualification and priority
    always_comb begin
        mchk_any = |(mchk_src & cur.hw_config[`MCHK_SRC_COUNT-1:0]);
        async_req = fld(cur.state_word, `POS_ASYNC_IRQ)
            & (ext_irq | dec_irq | mgmt_irq);
        fp_prog_req = fp_enabled_exc & fld(cur.state_word, `POS_FP_AVAIL)
            & (fld(cur.state_word, `POS_FPX_A) | fld(cur.state_word, `POS_FPX_B));
        trace_req = cur.trace_pending;
        kind = `EXC_SYNC_OTHER;
        voff = sync_vector;
        save_addr = complete_pc;
        info = sync_info;
        want = 1'b0;
        if (sys_reset_req) begin
            want = 1'b1;
            kind = `EXC_SYS_RESET;
            voff = `VOFF_SYS_RESET;
            save_addr = next_pc;
        end else if (mchk_any && fld(cur.state_word, `POS_MCHK_ENABLE)) begin
            want = 1'b1;
            kind = `EXC_MCHK;
            voff = `VOFF_MCHK;
            save_addr = next_pc;
        end else if (older_exc_pending) begin
            want = 1'b0;
        end else if (sync_exc) begin
            want = 1'b1;
        end else if (fp_instr_pending && !fld(cur.state_word, `POS_FP_AVAIL)) begin
            want = 1'b1;
            kind = `EXC_FP_UNAVAIL;
            voff = `VOFF_FP_UNAVAIL;
            info = 4'h0;
        end else if (fp_prog_req) begin
            want = 1'b1;
            kind = `EXC_PROGRAM;
            voff = `VOFF_PROGRAM;
            info = 4'h8;
        end else if (trace_req) begin
            want = 1'b1;
            kind = `EXC_TRACE;
            voff = `VOFF_TRACE;
            save_addr = next_pc;
            info = 4'h0;
        end else if (async_req) begin
            want = 1'b1;
            kind = ext_irq ? `EXC_EXTERNAL : (dec_irq ? `EXC_DECREMENTER : `EXC_SYS_MGMT);
            voff = ext_irq ? `VOFF_EXTERNAL : (dec_irq ? `VOFF_DECREMENTER : `VOFF_SYS_MGMT);
            save_addr = next_pc;
            info = 4'h0;
        end
    end

    // next-state logic
    always_comb begin
        nxt = cur;
        nxt.take = 1'b0;
        case (cur.state)
            st_run: begin
                // trace armed by completion under step or branch trace
                if (instr_complete && fld(cur.state_word, `POS_SINGLE_STEP))
                    nxt.trace_pending = 1'b1;
                if (branch_complete && fld(cur.state_word, `POS_BRANCH_TRACE))
                    nxt.trace_pending = 1'b1;
                if (reg_write) begin
                    case (reg_addr)
                        `OFF_STATE_WORD: nxt.state_word = reg_wdata;
                        `OFF_SAVE_PC: nxt.save_pc = reg_wdata;
                        `OFF_SAVE_STATE: nxt.save_state = reg_wdata;
                        `OFF_HW_CONFIG: nxt.hw_config = reg_wdata;
                        default: ;
                    endcase
                end
                if (mchk_any && !fld(cur.state_word, `POS_MCHK_ENABLE) && !sys_reset_req) begin
                    nxt.state = st_checkstop;
                    nxt.checkstop = 1'b1;
                end else if (want) begin
                    nxt.take = 1'b1;
                    // a completion that re-arms trace in this same cycle wins over the clear
                    if (kind == `EXC_TRACE
                        && !(instr_complete && fld(cur.state_word, `POS_SINGLE_STEP))
                        && !(branch_complete && fld(cur.state_word, `POS_BRANCH_TRACE)))
                        nxt.trace_pending = 1'b0;
                    nxt.save_pc = save_addr;
                    // info in 1..4, reserved 10..15 zero, copy 5..9 and 16..31
                    nxt.save_state = (cur.state_word & `SAVE_COPY_MASK)
                        | {1'b0, info, 27'h0};
                    // same fields cleared for every kind; machine check also clears the enable, system reset sets the prefix
                    nxt.state_word = cur.state_word & (`SAVE_COPY_MASK
                        & ~32'h0000fffe) | (cur.state_word & 32'h00010040);
                    nxt.state_word[31 - `POS_ASYNC_IRQ] = 1'b0;
                    nxt.state_word[31 - `POS_MCHK_ENABLE] =
                        (kind == `EXC_MCHK) ? 1'b0 : fld(cur.state_word, `POS_MCHK_ENABLE);
                    nxt.state_word[31 - `POS_VECTOR_HIGH] =
                        (kind == `EXC_SYS_RESET) ? 1'b1 : fld(cur.state_word, `POS_VECTOR_HIGH);
                    nxt.state_word[31 - `POS_INSTR_XLATE] = 1'b0;
                    nxt.state_word[31 - `POS_DATA_XLATE] = 1'b0;
                    nxt.state_word[31 - `POS_HANDLER_ENDIAN] =
                        fld(cur.state_word, `POS_HANDLER_ENDIAN);
                    nxt.state_word[31 - `POS_BYTE_ORDER] =
                        fld(cur.state_word, `POS_HANDLER_ENDIAN);
                    nxt.fetch_addr = vec_addr(cur.state_word, voff);
                end
            end
            st_checkstop: begin
                nxt.checkstop = 1'b1;
            end
            default: nxt.state = st_run;
        endcase
        nxt.fp_dispatch_ok = fld(nxt.state_word, `POS_FP_AVAIL) & (nxt.state == st_run);
        nxt.rdata = 32'h0;
        if (reg_read) begin
            case (reg_addr)
                `OFF_STATE_WORD: nxt.rdata = cur.state_word;
                `OFF_SAVE_PC: nxt.rdata = cur.save_pc;
                `OFF_SAVE_STATE: nxt.rdata = cur.save_state;
                `OFF_HW_CONFIG: nxt.rdata = cur.hw_config;
                `OFF_STATUS: nxt.rdata = {30'h0, cur.trace_pending, cur.checkstop};
                default: nxt.rdata = 32'h0;
            endcase
        end
    end

    // state register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cur <= '0;
            cur.state <= st_run;
            cur.state_word <= `STATE_WORD_RESET;
            cur.hw_config <= `HW_CONFIG_RESET;
        end else begin
            cur <= nxt;
        end
    end

    // outputs straight from the state register
    assign reg_rdata = cur.rdata;
    assign exc_taken = cur.take;
    assign exc_fetch_addr = cur.fetch_addr;
    assign fp_dispatch_ok = cur.fp_dispatch_ok;
    assign instr_xlate_on = fld(cur.state_word, `POS_INSTR_XLATE);
    assign data_xlate_on = fld(cur.state_word, `POS_DATA_XLATE);
    assign byte_order_swap = fld(cur.state_word, `POS_BYTE_ORDER);
    assign checkstop = cur.checkstop;

    a_xlate_cleared: assert property (@(posedge sys_clk) disable iff (rst)
        exc_taken |-> !instr_xlate_on && !data_xlate_on)
        else $error("translation left on after entry");
    a_endian_copy: assert property (@(posedge sys_clk) disable iff (rst)
        exc_taken |-> byte_order_swap == $past(fld(cur.state_word, `POS_HANDLER_ENDIAN)))
        else $error("byte order not taken from handler select");
    a_async_clear: assert property (@(posedge sys_clk) disable iff (rst)
        exc_taken |-> !fld(cur.state_word, `POS_ASYNC_IRQ))
        else $error("async enable not cleared");
    a_checkstop_hold: assert property (@(posedge sys_clk) disable iff (rst)
        checkstop |=> checkstop && !exc_taken)
        else $error("checkstop released");
    a_mchk_stop: assert property (@(posedge sys_clk) disable iff (rst)
        (cur.state == st_run) && (|(mchk_src & cur.hw_config[3:0]))
        && !fld(cur.state_word, `POS_MCHK_ENABLE) && !sys_reset_req |=> checkstop)
        else $error("disabled machine check did not stop");
    a_reset_taken: assert property (@(posedge sys_clk) disable iff (rst)
        (cur.state == st_run) && sys_reset_req |=> exc_taken
        && (exc_fetch_addr == {`VEC_BASE_HIGH, `VOFF_SYS_RESET}
        || exc_fetch_addr == {`VEC_BASE_LOW, `VOFF_SYS_RESET}))
        else $error("system reset not taken");
    a_save_copy: assert property (@(posedge sys_clk) disable iff (rst)
        exc_taken |-> (cur.save_state & `SAVE_COPY_MASK)
        == ($past(cur.state_word) & `SAVE_COPY_MASK))
        else $error("state copy missing from save register");
    a_vec_base: assert property (@(posedge sys_clk) disable iff (rst)
        exc_taken && !$past(sys_reset_req) |-> exc_fetch_addr[31:20]
        == ($past(fld(cur.state_word, `POS_VECTOR_HIGH)) ? `VEC_BASE_HIGH : `VEC_BASE_LOW))
        else $error("vector base wrong");
    a_older_block: assert property (@(posedge sys_clk) disable iff (rst)
        older_exc_pending && !sys_reset_req && !(|mchk_src) |=> !exc_taken)
        else $error("taken past older fault");
    a_fp_gate: assert property (@(posedge sys_clk) disable iff (rst)
        fp_dispatch_ok |-> fld(cur.state_word, `POS_FP_AVAIL))
        else $error("fp dispatch allowed while unavailable");

endmodule : exc_entry

// [rtl/exc_entry_regs.svh]
// offsets, field positions, reset values and encodings for exception entry
`ifndef EXC_ENTRY_REGS_SVH
`define EXC_ENTRY_REGS_SVH

// register port offsets (word addresses on the plain port)
`define OFF_STATE_WORD 4'h0
`define OFF_SAVE_PC 4'h1
`define OFF_SAVE_STATE 4'h2
`define OFF_HW_CONFIG 4'h3
`define OFF_STATUS 4'h4

// state word field positions (bit 0 is the most significant bit)
`define POS_HANDLER_ENDIAN 15
`define POS_ASYNC_IRQ 16
`define POS_FP_AVAIL 18
`define POS_MCHK_ENABLE 19
`define POS_FPX_A 20
`define POS_SINGLE_STEP 21
`define POS_BRANCH_TRACE 22
`define POS_FPX_B 23
`define POS_VECTOR_HIGH 25
`define POS_INSTR_XLATE 26
`define POS_DATA_XLATE 27
`define POS_RECOVERABLE 30
`define POS_BYTE_ORDER 31

// saved-state bits copied from the state word: 5..9 and 16..31
`define SAVE_COPY_MASK 32'h07c0ffff
// bits set aside for exception-specific information: 1..4 loaded, 10..15 held zero
`define SAVE_INFO_MASK 32'h783f0000

// vector bases
`define VEC_BASE_LOW 12'h000
`define VEC_BASE_HIGH 12'hfff

// reset values
`define STATE_WORD_RESET 32'h00000040
`define HW_CONFIG_RESET 32'h00000000

// exception kind codes and their vector offsets (20 bits)
`define EXC_SYS_RESET 4'h0
`define EXC_MCHK 4'h1
`define EXC_EXTERNAL 4'h2
`define EXC_DECREMENTER 4'h3
`define EXC_SYS_MGMT 4'h4
`define EXC_PROGRAM 4'h5
`define EXC_FP_UNAVAIL 4'h6
`define EXC_TRACE 4'h7
`define EXC_SYNC_OTHER 4'h8

`define VOFF_SYS_RESET 20'h00100
`define VOFF_MCHK 20'h00200
`define VOFF_EXTERNAL 20'h00500
`define VOFF_PROGRAM 20'h00700
`define VOFF_FP_UNAVAIL 20'h00800
`define VOFF_DECREMENTER 20'h00900
`define VOFF_TRACE 20'h00d00
`define VOFF_SYS_MGMT 20'h01400

// hardware configuration register: per-source machine check enables, bits 0..3
`define MCHK_SRC_COUNT 4

`endif

// [rtl/exc_entry_pkg.sv]
// types for the exception entry block
package exc_entry_pkg;
    typedef enum logic [1:0] {
        st_run,
        st_checkstop
    } exc_state_t;

    typedef struct packed {
        exc_state_t state;
        logic [31:0] state_word;
        logic [31:0] save_pc;
        logic [31:0] save_state;
        logic [31:0] hw_config;
        logic [31:0] rdata;
        logic take;
        logic [31:0] fetch_addr;
        logic fp_dispatch_ok;
        logic trace_pending;
        logic checkstop;
    } exc_regs_t;
endpackage : exc_entry_pkg

// [bench/pipe_model.sv]
// model of the instruction pipeline and exception sources facing the entry block
`timescale 1ns/1ps

module pipe_model #(
    parameter logic [31:0] done_pc = 32'h00002000,
    parameter logic [31:0] after_pc = 32'h00002004
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // one command bit per source, from the bench
    input wire logic [12:0] cmd,
    // exception sources
    output logic sys_reset_req,
    output logic [3:0] mchk_src,
    output logic ext_irq,
    output logic dec_irq,
    output logic mgmt_irq,
    output logic fp_enabled_exc,
    output logic fp_instr_pending,
    output logic sync_exc,
    // completion status
    output logic instr_complete,
    output logic branch_complete,
    output logic [31:0] complete_pc,
    output logic [31:0] next_pc
);
    // sources rise one edge after their command, like a pipeline stage would raise them
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            {branch_complete, instr_complete, sync_exc, fp_instr_pending, fp_enabled_exc,
                mgmt_irq, dec_irq, ext_irq, mchk_src, sys_reset_req} <= '0;
        end else begin
            {branch_complete, instr_complete, sync_exc, fp_instr_pending, fp_enabled_exc,
                mgmt_irq, dec_irq, ext_irq, mchk_src, sys_reset_req} <= cmd;
        end
    end

    // addresses of the completing and of the following instruction
    assign complete_pc = done_pc;
    assign next_pc = after_pc;
endmodule : pipe_model

// [bench/tb.sv]
// self-checking bench for the exception entry block
`timescale 1ns/1ps
`include "exc_entry_regs.svh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end

module tb;
    logic sys_clk, rst, reg_write, reg_read, older_exc_pending, sys_reset_req, ext_irq, dec_irq;
    logic mgmt_irq, fp_enabled_exc, fp_instr_pending, sync_exc, instr_complete, branch_complete;
    logic exc_taken, fp_dispatch_ok, instr_xlate_on, data_xlate_on, byte_order_swap, checkstop;
    logic [3:0] reg_addr, sync_info, mchk_src;
    logic [31:0] reg_wdata, reg_rdata, exc_fetch_addr, complete_pc, next_pc, d, sw;
    logic [19:0] sync_vector;
    logic [12:0] cmd;
    int n_mismatch = 0;
    int checks_done = 0;
    localparam logic [31:0] CPC = 32'h00002000;
    localparam logic [31:0] NPC = 32'h00002004;

    exc_entry DUT (
        .sys_clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .sys_reset_req, .mchk_src, .ext_irq, .dec_irq, .mgmt_irq, .fp_enabled_exc,
        .fp_instr_pending, .sync_exc, .sync_vector, .sync_info, .older_exc_pending,
        .instr_complete, .branch_complete, .complete_pc, .next_pc, .exc_taken,
        .exc_fetch_addr, .fp_dispatch_ok, .instr_xlate_on, .data_xlate_on,
        .byte_order_swap, .checkstop
    );
    pipe_model #(.done_pc(CPC), .after_pc(NPC)) partner (
        .sys_clk, .rst, .cmd, .sys_reset_req, .mchk_src, .ext_irq, .dec_irq, .mgmt_irq,
        .fp_enabled_exc, .fp_instr_pending, .sync_exc, .instr_complete, .branch_complete,
        .complete_pc, .next_pc
    );

    // state word bit n in big-endian numbering
    function automatic logic [31:0] fb(input int n);
        return 32'h00000001 << (31 - n);
    endfunction : fb

    // verdict and end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    // register port cycles
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        @(negedge sys_clk);
        v = reg_rdata;
    endtask : rd

    // one-cycle command to the partner
    task automatic pulse(input int i);
        @(posedge sys_clk);
        cmd[i] <= 1'b1;
        @(posedge sys_clk);
        cmd[i] <= 1'b0;
    endtask : pulse

    // wait for one entry pulse and check where fetch goes
    task automatic entry(input logic [31:0] addr);
        int i;
        i = 0;
        do begin
            @(negedge sys_clk);
            i++;
        end while (exc_taken !== 1'b1 && i < 8);
        if (exc_taken !== 1'b1) begin
            n_mismatch++;
            $display("[ERR] exc_taken exp 1 got 0");
            complete_run();
        end
        `CHK("exc_fetch_addr", addr, exc_fetch_addr)
        @(negedge sys_clk);
        `CHK("exc_taken width", 1'b0, exc_taken)
    endtask : entry

    task automatic none(input int n);
        repeat (n) begin
            @(negedge sys_clk);
            `CHK("no entry", 1'b0, exc_taken)
        end
    endtask : none

    // clock and watchdog
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        #1000000;
        n_mismatch++;
        $display("[ERR] watchdog exp done got hang");
        complete_run();
    end

    // test sequence
    initial begin
        rst = 1'b1;
        cmd = '0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        older_exc_pending = 1'b0;
        sync_vector = 20'h00300;
        sync_info = 4'h9;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        rd(`OFF_STATE_WORD, d);
        `CHK("state word reset", `STATE_WORD_RESET, d)
        rd(`OFF_HW_CONFIG, d);
        `CHK("hw config reset", `HW_CONFIG_RESET, d)
        rd(4'h9, d);
        `CHK("unmapped read", 32'h00000000, d)
        $display("test reset done");
        sw = fb(5) | fb(`POS_INSTR_XLATE) | fb(`POS_DATA_XLATE) | fb(`POS_FP_AVAIL)
            | fb(`POS_MCHK_ENABLE) | fb(`POS_BYTE_ORDER) | fb(`POS_HANDLER_ENDIAN)
            | fb(`POS_RECOVERABLE) | fb(`POS_ASYNC_IRQ) | fb(`POS_VECTOR_HIGH);
        wr(`OFF_STATE_WORD, sw);
        @(negedge sys_clk);
        `CHK("mode outputs", 4'hf, {instr_xlate_on, data_xlate_on, fp_dispatch_ok, byte_order_swap})
        pulse(10);
        entry({`VEC_BASE_HIGH, sync_vector});
        `CHK("xlate after entry", 2'b00, {instr_xlate_on, data_xlate_on})
        `CHK("fp and order after entry", 2'b01, {fp_dispatch_ok, byte_order_swap})
        rd(`OFF_SAVE_STATE, d);
        `CHK("saved state copy", sw & `SAVE_COPY_MASK, d & `SAVE_COPY_MASK)
        `CHK("saved info", sync_info, d[30:27])
        rd(`OFF_SAVE_PC, d);
        `CHK("save_pc sync", CPC, d)
        rd(`OFF_STATE_WORD, d);
        `CHK("new state word", fb(5) | fb(15) | fb(19) | fb(25) | fb(31), d)
        $display("test sync entry done");
        for (int k = 0; k < 3; k++) begin
            @(posedge sys_clk) cmd[5 + k] <= 1'b1;
            none(4);
            wr(`OFF_STATE_WORD, fb(`POS_ASYNC_IRQ) | fb(`POS_VECTOR_HIGH));
            entry({`VEC_BASE_HIGH, k == 0 ? `VOFF_EXTERNAL : k == 1 ? `VOFF_DECREMENTER
                : `VOFF_SYS_MGMT});
            rd(`OFF_SAVE_PC, d);
            `CHK("save_pc async", NPC, d)
            @(posedge sys_clk) cmd[5 + k] <= 1'b0;
        end
        $display("test async done");
        @(posedge sys_clk) older_exc_pending <= 1'b1;
        pulse(10);
        none(4);
        wr(`OFF_STATE_WORD, fb(`POS_VECTOR_HIGH));
        pulse(0);
        entry({`VEC_BASE_HIGH, `VOFF_SYS_RESET});
        rd(`OFF_STATE_WORD, d);
        `CHK("state after reset exc", fb(`POS_VECTOR_HIGH), d)
        @(posedge sys_clk) older_exc_pending <= 1'b0;
        $display("test order done");
        pulse(9);
        entry({`VEC_BASE_HIGH, `VOFF_FP_UNAVAIL});
        for (int m = 0; m < 4; m++) begin
            sw = fb(`POS_VECTOR_HIGH) | fb(`POS_FP_AVAIL) | (m[1] ? fb(`POS_FPX_A) : 0)
                | (m[0] ? fb(`POS_FPX_B) : 0);
            wr(`OFF_STATE_WORD, sw);
            @(negedge sys_clk);
            `CHK("fp dispatch", 1'b1, fp_dispatch_ok)
            pulse(8);
            if (m == 0) begin
                none(4);
            end else begin
                entry({`VEC_BASE_HIGH, `VOFF_PROGRAM});
            end
        end
        $display("test fp done");
        wr(`OFF_STATE_WORD, fb(`POS_VECTOR_HIGH) | fb(`POS_SINGLE_STEP));
        pulse(11);
        entry({`VEC_BASE_HIGH, `VOFF_TRACE});
        wr(`OFF_STATE_WORD, fb(`POS_VECTOR_HIGH) | fb(`POS_BRANCH_TRACE));
        pulse(11);
        none(4);
        pulse(12);
        entry({`VEC_BASE_HIGH, `VOFF_TRACE});
        $display("test trace done");
        wr(`OFF_STATE_WORD, fb(`POS_MCHK_ENABLE) | fb(`POS_RECOVERABLE));
        pulse(1);
        none(4);
        wr(`OFF_HW_CONFIG, 32'h00000001);
        pulse(1);
        entry({`VEC_BASE_LOW, `VOFF_MCHK});
        rd(`OFF_SAVE_STATE, d);
        `CHK("recoverable saved", 1'b1, d[31 - `POS_RECOVERABLE])
        rd(`OFF_STATE_WORD, d);
        `CHK("state after mchk", 32'h00000000, d)
        pulse(1);
        for (int i = 0; i < 8 && checkstop !== 1'b1; i++) @(negedge sys_clk);
        `CHK("checkstop", 1'b1, checkstop)
        if (checkstop !== 1'b1) complete_run();
        wr(`OFF_STATE_WORD, fb(`POS_VECTOR_HIGH));
        rd(`OFF_STATE_WORD, d);
        `CHK("write in checkstop", 32'h00000000, d)
        rd(`OFF_STATUS, d);
        `CHK("status checkstop", 1'b1, d[0])
        pulse(0);
        none(4);
        `CHK("checkstop held", 1'b1, checkstop)
        @(posedge sys_clk) rst <= 1'b1;
        @(posedge sys_clk) rst <= 1'b0;
        @(negedge sys_clk);
        `CHK("checkstop cleared", 1'b0, checkstop)
        rd(`OFF_STATE_WORD, d);
        `CHK("state after hard reset", `STATE_WORD_RESET, d)
        $display("test machine check done");
        complete_run();
    end
endmodule : tb
